// file: verilog/codec_clk_pkg.sv
// Package: constants and types for the codec clock-mode block
package codec_clk_pkg;
    // System clock and register port
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] REF_ADDR = 4'h4;
    localparam logic [3:0] STAT_ADDR = 4'h8;
    // Control register bit positions
    localparam int PLL_BIT = 0;
    localparam int MSTR_BIT = 1;
    localparam int MASTER_CLOCK_OUT_BIT = 2;
    localparam int BCK_BIT = 3;
    localparam int VREF_BIT = 4;
    localparam int DAC_BIT = 5;
    localparam int ADCL_BIT = 6;
    localparam int ADCR_BIT = 7;
    localparam int DIV_LSB = 8;
    localparam int CTRL_W = 10;
    // Reference register: select in [3:0], rate in [7:4]
    localparam int RATE_LSB = 4;
    localparam int REF_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
    localparam logic [REF_W-1:0] REF_RESET = 8'h00;
    // Lock times in ms, then in cycles
    localparam int LOCK_FRAME_MS = 160;
    localparam int LOCK_BIT_MS = 2;
    localparam int LOCK_MCLK_MS = 10;
    localparam int CYC_PER_MS = SYS_CLK_HZ / 1000;
    localparam int LOCK_FRAME_CYC = LOCK_FRAME_MS * CYC_PER_MS;
    localparam int LOCK_BIT_CYC = LOCK_BIT_MS * CYC_PER_MS;
    localparam int LOCK_MCLK_CYC = LOCK_MCLK_MS * CYC_PER_MS;
    localparam int LOCK_W = 23;
    // Master clock input counts as absent after this many quiet cycles
    localparam int MCLK_IDLE_CYC = 255;
    localparam int IDLE_W = 8;
    // Tick generator: 512 ticks per sample period
    localparam int NCO_W = 24;
    localparam int TICKS_PER_FS = 512;
    localparam int DIV_W = 9;
    localparam int FRAME_BIT = 8;
    localparam int BCK64_BIT = 2;
    localparam int BCK32_BIT = 3;

    typedef enum logic [1:0] {
        MODE_EXT_SLAVE = 2'b00,
        MODE_EXT_MASTER = 2'b01,
        MODE_PLL_SLAVE = 2'b10,
        MODE_PLL_MASTER = 2'b11
    } clk_mode_e;

    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_LOCKING = 2'b01,
        PLL_LOCKED = 2'b10
    } pll_state_e;

    typedef logic [NCO_W-1:0] inc_t;

    function automatic inc_t nco_inc(input int hz);
        longint p;
        p = longint'(hz) * TICKS_PER_FS * (longint'(1) << NCO_W) / SYS_CLK_HZ;
        return p[NCO_W-1:0];
    endfunction : nco_inc

    // Per rate code with master-clock reference; zero marks unavailable
    localparam inc_t FS_INC [16] = '{
        nco_inc(8000), nco_inc(12000), nco_inc(16000), nco_inc(24000),
        nco_inc(7350), nco_inc(11025), nco_inc(14700), nco_inc(22050),
        '0, '0, nco_inc(32000), nco_inc(48000),
        '0, '0, nco_inc(29400), nco_inc(44100)};
    // Range top for frame or bit clock reference
    localparam inc_t RANGE_INC [4] = '{
        nco_inc(12000), nco_inc(24000), nco_inc(48000), '0};
endpackage : codec_clk_pkg

// file: verilog/rate_nco.sv
// Phase accumulator producing sample-rate ticks
`timescale 1ns/1ps
module rate_nco #(
    parameter int W = codec_clk_pkg::NCO_W
) (
    input wire logic clk_sys_i, // System clock
    input wire logic sys_rst_i, // Sync reset
    input wire logic run_i, // Accumulate
    input wire logic [W-1:0] inc_i, // Phase step
    output logic tick_o // One-cycle tick
);
    logic [W-1:0] acc_q;
    logic [W:0] sum;

    // One extra bit keeps the carry that marks a tick
    assign sum = {1'b0, acc_q} + {1'b0, inc_i};

    // Carry out is the tick; cleared when stopped for a clean restart
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !run_i) begin
            acc_q <= '0;
            tick_o <= 1'b0;
        end else begin
            acc_q <= sum[W-1:0];
            tick_o <= sum[W];
        end
    end
endmodule : rate_nco

// file: verilog/lock_timer.sv
// Down counter modelling the PLL lock wait
`timescale 1ns/1ps
module lock_timer #(
    parameter int W = codec_clk_pkg::LOCK_W
) (
    input wire logic clk_sys_i, // System clock
    input wire logic sys_rst_i, // Sync reset
    input wire logic load_i, // Restart wait
    input wire logic [W-1:0] count_i, // Wait in cycles
    output logic done_o // One-cycle end pulse
);
    logic [W-1:0] cnt_q;

    // Reload wins over the running count
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_q <= count_i;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_q == W'(1));
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end
endmodule : lock_timer

// file: verilog/codec_clock_mode_control.sv
// Clock-mode control: mode decode, PLL lock wait, clock pin generation
`timescale 1ns/1ps
module codec_clock_mode_control #(
    parameter int LOCK_FRAME_CYC = codec_clk_pkg::LOCK_FRAME_CYC,
    parameter int LOCK_BIT_CYC = codec_clk_pkg::LOCK_BIT_CYC,
    parameter int LOCK_MCLK_CYC = codec_clk_pkg::LOCK_MCLK_CYC
) (
    input wire logic clk_sys_i, // 40 MHz system clock
    input wire logic sys_rst_i, // Sync reset, active high
    input wire logic powerdown_pin_n_i, // Power-down pin, low resets
    input wire logic [codec_clk_pkg::ADDR_W-1:0] addr_i, // Register address
    input wire logic [codec_clk_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [codec_clk_pkg::DATA_W-1:0] rdata_o, // Read data, next cycle
    input wire logic master_clock_in_i, // Master clock input level
    output logic master_clock_out_o, // Master clock output
    input wire logic frame_clock_i, // Frame clock pin level
    output logic frame_clock_o, // Frame clock drive
    output logic frame_clock_oe_o, // Frame clock enable
    input wire logic bit_clock_i, // Bit clock pin level
    output logic bit_clock_o, // Bit clock drive
    output logic bit_clock_oe_o // Bit clock enable
);
    import codec_clk_pkg::*;

    logic rst_all;
    logic [CTRL_W-1:0] ctrl_q;
    logic [REF_W-1:0] ref_q;
    logic pll_en;
    logic mstr;
    logic mck_en;
    logic vref;
    logic [3:0] ref_sel;
    logic [3:0] rate;
    clk_mode_e mode;
    logic ref_ok;
    logic rate_ok;
    logic cfg_ok;
    inc_t inc;
    logic nco_tick;
    logic pll_prev_q;
    logic [REF_W-1:0] ref_prev_q;
    logic restart;
    logic [LOCK_W-1:0] lock_cnt;
    logic lock_done;
    pll_state_e lock_st_q;
    logic min_q;
    logic mclk_edge;
    logic [1:0] pre_q;
    logic [1:0] pre_max;
    logic [IDLE_W-1:0] idle_q;
    logic clk_present;
    logic tick;
    logic run;
    logic run_m;
    logic [DIV_W-1:0] div_q;
    logic inv_q;
    logic frame_run_q;
    logic [7:0] status;

    // Power-down pin acts as a second synchronous reset
    assign rst_all = sys_rst_i | ~powerdown_pin_n_i;

    // Register writes; both fields start cleared, so slave after reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_i && addr_i == CTRL_ADDR) begin
            ctrl_q <= wdata_i[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            ref_q <= REF_RESET;
        end else if (wr_i && addr_i == REF_ADDR) begin
            ref_q <= wdata_i[REF_W-1:0];
        end
    end

    // Field views of the stored bits
    assign pll_en = ctrl_q[PLL_BIT];
    assign mstr = ctrl_q[MSTR_BIT];
    assign mck_en = ctrl_q[MASTER_CLOCK_OUT_BIT];
    assign vref = ctrl_q[VREF_BIT];
    assign ref_sel = ref_q[3:0];
    assign rate = ref_q[RATE_LSB +: 4];

    // Mode is pure decode of the stored bits, never a state
    assign mode = clk_mode_e'({pll_en, mstr});

    // Reference select decode
    always_comb begin
        case (ref_sel)
            4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hC, 4'hD: ref_ok = 1'b1;
            default: ref_ok = 1'b0;
        endcase
    end

    // Rate decode; bit 2 of the select means master-clock reference
    always_comb begin
        if (ref_sel[2]) begin
            inc = FS_INC[rate];
        end else begin
            inc = RANGE_INC[rate[3:2]];
        end
        rate_ok = (inc != '0);
    end

    // External modes skip the validity check on both select fields
    assign cfg_ok = pll_en ? (ref_ok & rate_ok) : 1'b1;

    // PLL stand-in: tick rate follows the decoded selects
    rate_nco #(
        .W(NCO_W)
    ) u_nco (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(rst_all),
        .run_i(pll_en & cfg_ok),
        .inc_i(inc),
        .tick_o(nco_tick)
    );

    // Restart the lock wait on PLL power-up or any select change
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            pll_prev_q <= 1'b0;
            ref_prev_q <= REF_RESET;
        end else begin
            pll_prev_q <= pll_en;
            ref_prev_q <= ref_q;
        end
    end

    assign restart = pll_en & (~pll_prev_q | (ref_q != ref_prev_q));

    // Lock wait per reference kind
    always_comb begin
        if (ref_sel[2]) begin
            lock_cnt = LOCK_W'(LOCK_MCLK_CYC);
        end else if (ref_sel[1]) begin
            lock_cnt = LOCK_W'(LOCK_BIT_CYC);
        end else begin
            lock_cnt = LOCK_W'(LOCK_FRAME_CYC);
        end
    end

    lock_timer #(
        .W(LOCK_W)
    ) u_lock (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(rst_all),
        .load_i(restart),
        .count_i(lock_cnt),
        .done_o(lock_done)
    );

    // Lock state; frame and bit clocks stay low until the wait ends
    always_ff @(posedge clk_sys_i) begin
        if (rst_all || !pll_en) begin
            lock_st_q <= PLL_OFF;
        end else if (restart) begin
            lock_st_q <= PLL_LOCKING;
        end else begin
            case (lock_st_q)
                PLL_OFF: lock_st_q <= PLL_LOCKING;
                PLL_LOCKING: lock_st_q <= lock_done ? PLL_LOCKED : PLL_LOCKING;
                PLL_LOCKED: lock_st_q <= PLL_LOCKED;
                default: lock_st_q <= PLL_OFF;
            endcase
        end
    end

    // Master clock input edges; the pin is synchronous to our clock
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            min_q <= 1'b0;
        end else begin
            min_q <= master_clock_in_i;
        end
    end

    assign mclk_edge = master_clock_in_i ^ min_q;

    // Both edges of a 256fs input give 512 ticks per sample
    always_comb begin
        case (rate[1:0])
            2'b01: pre_max = 2'd3;
            2'b10: pre_max = 2'd1;
            default: pre_max = 2'd0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            pre_q <= 2'd0;
        end else if (mclk_edge) begin
            pre_q <= (pre_q >= pre_max) ? 2'd0 : pre_q + 2'd1;
        end
    end

    // Presence detector so a stopped input clock stops the frame and bit clocks in external modes
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            idle_q <= IDLE_W'(MCLK_IDLE_CYC);
        end else if (mclk_edge) begin
            idle_q <= '0;
        end else if (idle_q != IDLE_W'(MCLK_IDLE_CYC)) begin
            idle_q <= idle_q + IDLE_W'(1);
        end
    end

    assign clk_present = pll_en ? (lock_st_q == PLL_LOCKED)
                                : (idle_q != IDLE_W'(MCLK_IDLE_CYC));
    assign tick = pll_en ? nco_tick : (mclk_edge & (pre_q >= pre_max));
    assign run = clk_present & cfg_ok;
    // ADC and DAC power bits take no part here
    assign run_m = run & mstr & vref;

    // Sample-period divider; held at zero so pins park low
    always_ff @(posedge clk_sys_i) begin
        if (rst_all || !run) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // Free toggle standing for the unlocked clock-out waveform
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            inv_q <= 1'b0;
        end else begin
            inv_q <= ~inv_q;
        end
    end

    // Pin enables follow the master bit; slaves leave pins to pulls
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            frame_clock_oe_o <= 1'b0;
            bit_clock_oe_o <= 1'b0;
        end else begin
            frame_clock_oe_o <= mstr;
            bit_clock_oe_o <= mstr;
        end
    end

    // Frame and bit clocks; in slave modes the host drives them
    always_ff @(posedge clk_sys_i) begin
        if (rst_all || !run_m) begin
            frame_clock_o <= 1'b0;
            bit_clock_o <= 1'b0;
            frame_run_q <= 1'b0;
        end else if (frame_run_q || div_q == '0) begin // Start on a wrap, no cut frame
            frame_clock_o <= div_q[FRAME_BIT];
            bit_clock_o <= ctrl_q[BCK_BIT] ? div_q[BCK64_BIT] : div_q[BCK32_BIT];
            frame_run_q <= 1'b1;
        end
    end

    // Clock out: divider in PLL modes, junk while unlocked or in external master, low in external slave
    always_ff @(posedge clk_sys_i) begin
        if (rst_all || !mck_en) begin
            master_clock_out_o <= 1'b0;
        end else if (mode == MODE_EXT_MASTER) begin
            master_clock_out_o <= inv_q;
        end else if (pll_en && lock_st_q != PLL_LOCKED) begin
            master_clock_out_o <= inv_q;
        end else if (pll_en && run) begin
            master_clock_out_o <= div_q[ctrl_q[DIV_LSB +: 2]];
        end else begin
            master_clock_out_o <= 1'b0;
        end
    end

    // Status view: pin levels, lock, run, config and mode
    assign status = {frame_clock_i, bit_clock_i, lock_st_q, run, cfg_ok, mode};

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_all || !rd_i) begin
            rdata_o <= '0;
        end else begin
            case (addr_i)
                CTRL_ADDR: rdata_o <= DATA_W'(ctrl_q);
                REF_ADDR: rdata_o <= DATA_W'(ref_q);
                STAT_ADDR: rdata_o <= DATA_W'(status);
                default: rdata_o <= '0;
            endcase
        end
    end

    // Checks on the logic above

    a_mode_decode: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (wr_i && addr_i == CTRL_ADDR)
        |=> mode == clk_mode_e'({$past(wdata_i[PLL_BIT]), $past(wdata_i[MSTR_BIT])}))
    else $error("mode does not follow written bits");

    a_invalid_mck: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (mode == MODE_EXT_MASTER && mck_en && $past(mode == MODE_EXT_MASTER && mck_en))
        |=> master_clock_out_o != $past(master_clock_out_o))
    else $error("clock out not toggling with PLL off");

    a_mck_low: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        !mck_en |=> !master_clock_out_o)
    else $error("clock out not low while disabled");

    a_frame_align: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (frame_clock_o != $past(frame_clock_o)) |-> !bit_clock_o)
    else $error("frame edge away from bit clock low");

    a_vref_gate: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (!vref || !mstr) |=> !frame_clock_o && !bit_clock_o)
    else $error("clocks out without vref and master");

    a_pdn_slave: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !powerdown_pin_n_i |=> !mstr ##1 !frame_clock_oe_o)
    else $error("not slave after power-down");

    a_pins_float: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        !mstr [*2] |-> !frame_clock_oe_o && !bit_clock_oe_o)
    else $error("pins driven in slave mode");

    a_lock_wait: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (pll_en && !pll_prev_q) |=> lock_st_q == PLL_LOCKING ##1 !frame_clock_o)
    else $error("no lock wait after PLL power-up");

    a_reserved_off: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        !cfg_ok |=> !frame_clock_o && !bit_clock_o && div_q == '0)
    else $error("clocks run on reserved code");

    a_read_status: assert property (
        @(posedge clk_sys_i) disable iff (rst_all)
        (rd_i && addr_i == STAT_ADDR) |=> rdata_o == DATA_W'($past(status)))
    else $error("status read mismatch");
endmodule : codec_clock_mode_control

// file: testbench/codec_host_model.sv
// Audio host model: master clock source and slave-side serial clocks
`timescale 1ns/1ps
module codec_host_model #(
    parameter int MCLK_HALF = 4
) (
    input wire logic clk_sys_i, // System clock
    input wire logic mclk_en_i, // Run master clock
    input wire logic frame_oe_i, // Codec drives frame pin
    input wire logic frame_drv_i, // Codec frame drive value
    input wire logic bit_oe_i, // Codec drives bit pin
    input wire logic bit_drv_i, // Codec bit drive value
    output logic master_clock_o, // Master clock to codec
    output logic frame_pin_o, // Resolved frame pin level
    output logic bit_pin_o // Resolved bit pin level
);
    int mdiv = 0;
    logic mclk_q = 1'b0;
    logic [7:0] scnt = 8'h00;
    // Master clock stands low while disabled, so absence is detectable
    always @(posedge clk_sys_i) begin
        mdiv <= (mdiv == MCLK_HALF - 1) ? 0 : mdiv + 1;
        if (!mclk_en_i) mclk_q <= 1'b0;
        else if (mdiv == MCLK_HALF - 1) mclk_q <= !mclk_q;
        scnt <= scnt + 8'h01;
    end
    assign master_clock_o = mclk_q;
    // Host drives 64 bit periods per frame whenever the codec listens
    assign bit_pin_o = bit_oe_i ? bit_drv_i : scnt[1];
    assign frame_pin_o = frame_oe_i ? frame_drv_i : scnt[7];
endmodule : codec_host_model

// file: testbench/codec_clock_mode_control_bench.sv
// Self-checking bench for the codec clock-mode block
`timescale 1ns/1ps
module codec_clock_mode_control_bench;
    import codec_clk_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pdn_n = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic mclk_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] got;
    logic [DATA_W-1:0] d;
    logic mclk, master_clock_out, fr_pin, fr_o, fr_oe, bk_pin, bk_o, bk_oe;
    logic [15:0] lfsr = 16'h0051;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int fcyc, bedges, medges;

    // Clock at 40 MHz
    initial forever #12.5 clk_sys_i = !clk_sys_i;

    codec_clock_mode_control #(
        .LOCK_FRAME_CYC(40), .LOCK_BIT_CYC(20), .LOCK_MCLK_CYC(30)
    ) i_dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .powerdown_pin_n_i(pdn_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .master_clock_in_i(mclk), .master_clock_out_o(master_clock_out),
        .frame_clock_i(fr_pin), .frame_clock_o(fr_o), .frame_clock_oe_o(fr_oe),
        .bit_clock_i(bk_pin), .bit_clock_o(bk_o), .bit_clock_oe_o(bk_oe)
    );

    codec_host_model #(.MCLK_HALF(4)) i_host (
        .clk_sys_i(clk_sys_i), .mclk_en_i(mclk_en), .frame_oe_i(fr_oe),
        .frame_drv_i(fr_o), .bit_oe_i(bk_oe), .bit_drv_i(bk_o),
        .master_clock_o(mclk), .frame_pin_o(fr_pin), .bit_pin_o(bk_pin)
    );

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd

    // Expected configuration validity in PLL modes
    function automatic logic cfg_exp(input logic [3:0] r, input logic [3:0] f);
        logic ok_ref;
        ok_ref = r inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'hC, 4'hD};
        if (r[2]) return ok_ref && !(f inside {4'h8, 4'h9, 4'hC, 4'hD});
        return ok_ref && (f[3:2] != 2'b11);
    endfunction : cfg_exp

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data is valid only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_sys_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg

    // One full frame period from frame rise to frame rise, edges counted
    task automatic measure();
        logic pf, pb, pm, rise;
        int n;
        fcyc = 0;
        bedges = 0;
        medges = 0;
        @(negedge clk_sys_i);
        pf = fr_o;
        for (n = 0; n < 20000 && !(fr_o && !pf); n++) begin
            pf = fr_o;
            @(negedge clk_sys_i);
        end
        pf = fr_o;
        pb = bk_o;
        pm = master_clock_out;
        do begin
            @(negedge clk_sys_i);
            fcyc++;
            bedges += int'(bk_o && !pb);
            medges += int'(master_clock_out && !pm);
            rise = fr_o && !pf;
            pf = fr_o;
            pb = bk_o;
            pm = master_clock_out;
        end while (!rise && fcyc < 20000);
    endtask : measure

    // Hang guard a little above the expected run length
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd_reg(CTRL_ADDR);
        chk(got, 16'h0000);
        rd_reg(REF_ADDR);
        chk(got, 16'h0000);
        rd_reg(STAT_ADDR);
        chk(got[1:0], 2'b00);
        chk({fr_oe, bk_oe}, 2'b00);
        rd_reg(4'hC);
        chk(got, 16'h0000);
        // Random readback; mode and pin enables follow the stored bits
        repeat (8) begin
            d = rnd();
            wr_reg(CTRL_ADDR, d);
            rd_reg(CTRL_ADDR);
            chk(got, {6'h00, d[9:0]});
            rd_reg(STAT_ADDR);
            chk(got[1:0], {d[0], d[1]});
            chk({fr_oe, bk_oe}, {d[1], d[1]});
            d = rnd();
            wr_reg(REF_ADDR, d);
            rd_reg(REF_ADDR);
            chk(got, {8'h00, d[7:0]});
        end
        for (int m = 0; m < 4; m++) begin
            wr_reg(CTRL_ADDR, 16'(m));
            rd_reg(STAT_ADDR);
            chk(got[1:0], {m[0], m[1]});
        end
        // Power-down pin returns the block to slave with pins released
        wr_reg(CTRL_ADDR, 16'h0012);
        @(posedge clk_sys_i);
        pdn_n <= 1'b0;
        @(posedge clk_sys_i);
        pdn_n <= 1'b1;
        rd_reg(CTRL_ADDR);
        chk(got, 16'h0000);
        chk({fr_oe, bk_oe}, 2'b00);
        // Every reference and rate code in PLL slave mode
        wr_reg(CTRL_ADDR, 16'h0001);
        for (int r = 0; r < 16; r++) begin
            for (int f = 0; f < 16; f++) begin
                wr_reg(REF_ADDR, {8'h00, 4'(f), 4'(r)});
                rd_reg(STAT_ADDR);
                chk(got[2], cfg_exp(4'(r), 4'(f)));
            end
        end
        // External master: ratio, bit rate, no clock out, ADC and DAC bits clear
        mclk_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            wr_reg(REF_ADDR, {8'h00, d[1:0], 2'(i), 4'h0});
            wr_reg(CTRL_ADDR, 16'h0012 | (16'(i % 2) << BCK_BIT));
            measure();
            measure();
            chk(fcyc, 2048 * ((i == 1) ? 4 : (i == 2) ? 2 : 1));
            chk(bedges, (i % 2) ? 64 : 32);
            chk(medges, 0);
        end
        // Clock out enabled without the PLL gives no steady level
        wr_reg(CTRL_ADDR, 16'h0016);
        measure();
        chk(medges > 0, 1'b1);
        // PLL master on an 11.2896 MHz reference at 48 kHz
        wr_reg(REF_ADDR, 16'h00B4);
        wr_reg(CTRL_ADDR, 16'h0017);
        rd_reg(STAT_ADDR);
        chk(got[5:4], 2'b01);
        repeat (40) @(posedge clk_sys_i);
        rd_reg(STAT_ADDR);
        chk(got[5:4], 2'b10);
        for (int dv = 0; dv < 4; dv++) begin
            wr_reg(CTRL_ADDR, 16'h0017 | (16'(dv) << DIV_LSB));
            measure();
            measure();
            chk(fcyc inside {833, 834}, 1'b1);
            chk(bedges, 32);
            chk(medges, 256 >> dv);
        end
        wrap_up();
    end
endmodule : codec_clock_mode_control_bench
